// File: mains_tie_breaker_command_logic_bench.sv
// bench for the mains and tie breaker command logic
`default_nettype none
module mains_tie_breaker_command_logic_bench
  import mtb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 10;
  localparam int LIM = 10 * TICK;
  localparam int B_AUTO = 17, B_ALT = 16, B_RTC = 14, B_RTO = 13;
  localparam int B_RMC = 12, B_RMO = 11, B_TCB = 10, B_MCB = 9;
  localparam int B_TWI = 8, B_MWI = 7, B_TCF = 6, B_MCF = 5, B_SOK = 1;
  localparam int B_GBF = 2;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  mtb_pins_s p, pin;
  logic t_fb, m_fb, dl_done;
  logic genset_run, automatic_mains_failure, dynamic_sync;
  logic signed [7:0] slip_freq_upper, slip_freq_lower;
  logic tie_close_out, tie_open_out, tie_sync_req, tie_deload_req;
  logic mains_close_out, mains_open_out, mains_sync_req;
  logic tie_withdrawn, mains_withdrawn;
  int err_total = 0, n_checks = 0, cycles = 0, both = 0, mx = 0;

  mtb_breaker_ctrl #(.TICK_CYCLES(TICK)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pins_in(pin), .genset_run,
    .automatic_mains_failure, .dynamic_sync, .slip_freq_upper,
    .slip_freq_lower, .tie_close_out, .tie_open_out, .tie_sync_req,
    .tie_deload_req, .mains_close_out, .mains_open_out, .mains_sync_req,
    .tie_withdrawn, .mains_withdrawn
  );
  mtb_breaker_model i_act (
    .pclk, .presetn, .slow, .tie_close_out, .tie_open_out,
    .mains_close_out, .mains_open_out, .tie_deload_req,
    .tie_fb(t_fb), .mains_fb(m_fb), .deload_done(dl_done)
  );
  // contacts and deload status come from the model, the rest from us
  always_comb begin
    pin = p;
    pin.tie_closed_fb = t_fb;
    pin.mains_closed_fb = m_fb;
    pin.deload_done = dl_done;
  end
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // longest spell of both closed, and the guard against a hang
  always @(posedge pclk) begin
    both = (t_fb && m_fb) ? both + 1 : 0;
    if (both > mx) mx = both;
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic b1(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  // checks sit on the falling edge, where outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(negedge pclk);
  endtask
  task automatic setp(input int b, input logic v);
    @(posedge pclk);
    p[b] <= v;
  endtask
  // held four cycles so the two-flop sync surely sees the rise
  task automatic pulse(input int b);
    setp(b, 1'b1);
    repeat (4) @(posedge pclk);
    p[b] <= 1'b0;
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] q;
    logic e;
    xfer(1'b0, a, 32'h0, q, e);
    chk(q, x);
    b1(e, xe);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    slow = 1'b0;
    p = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    cyc(1);
    b1(dynamic_sync, 1'b1);
    chk({24'h0, slip_freq_upper}, 32'h3);
    chk({24'h0, slip_freq_lower}, 32'h0);
    rd(MTB_ADDR_CTRL, 32'h25, 1'b0);
    rd(MTB_ADDR_SLIP, 32'h3, 1'b0);
    rd(MTB_ADDR_OVL, 32'h64, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    wr(MTB_ADDR_SLIP, 32'hf907);
    rd(MTB_ADDR_SLIP, 32'hfb05, 1'b0);
    cyc(1);
    chk({24'h0, slip_freq_lower}, 32'hfb);
    wr(MTB_ADDR_SLIP, 32'h04ff);
    rd(MTB_ADDR_SLIP, 32'h0300, 1'b0);
    wr(MTB_ADDR_OVL, 32'h5);
    rd(MTB_ADDR_OVL, 32'h0a, 1'b0);
    wr(MTB_ADDR_OVL, 32'h3000);
    rd(MTB_ADDR_OVL, 32'h2706, 1'b0);
    wr(MTB_ADDR_OVL, 32'h0a);
    // both close commands meet blocks or an uncharged spring
    setp(B_MCF, 1'b1);
    setp(B_TCB, 1'b1);
    setp(B_MCB, 1'b1);
    pulse(B_RTC);
    pulse(B_RMC);
    cyc(10);
    b1(tie_close_out, 1'b0);
    b1(mains_close_out, 1'b0);
    setp(B_TCB, 1'b0);
    cyc(10);
    b1(tie_close_out, 1'b0);
    setp(B_MCB, 1'b0);
    cyc(10);
    b1(m_fb, 1'b1);
    setp(B_TCF, 1'b1);
    cyc(10);
    b1(tie_sync_req, 1'b1);
    b1(t_fb, 1'b0);
    setp(B_SOK, 1'b1);
    cyc(10);
    b1(t_fb, 1'b1);
    cyc(300);
    b1(m_fb, 1'b1);
    wr(MTB_ADDR_CTRL, 32'h07);
    cyc(300);
    b1(t_fb && m_fb, 1'b1);
    // tie open with mains closed must deload first
    @(posedge pclk);
    slow <= 1'b1;
    pulse(B_RTO);
    cyc(1);
    b1(tie_deload_req, 1'b1);
    cyc(30);
    b1(t_fb, 1'b0);
    @(posedge pclk);
    slow <= 1'b0;
    // overlap: whichever closed first is tripped in time
    wr(MTB_ADDR_CTRL, 32'h27);
    mx = 0;
    pulse(B_RTC);
    cyc(200);
    b1(m_fb, 1'b0);
    b1(t_fb, 1'b1);
    b1(mx < LIM, 1'b1);
    mx = 0;
    pulse(B_RMC);
    cyc(200);
    b1(t_fb, 1'b0);
    b1(m_fb, 1'b1);
    b1(mx < LIM, 1'b1);
    pulse(B_RMO);
    cyc(1);
    b1(mains_open_out, 1'b1);
    cyc(10);
    b1(m_fb, 1'b0);
    setp(B_TWI, 1'b1);
    setp(B_MWI, 1'b1);
    cyc(8);
    b1(tie_withdrawn, 1'b1);
    b1(mains_withdrawn, 1'b1);
    rd(MTB_ADDR_STAT, 32'he00, 1'b0);
    // generator closed: mains close must wait for the synchroniser
    setp(B_SOK, 1'b0);
    setp(B_GBF, 1'b1);
    pulse(B_RMC);
    cyc(1);
    b1(mains_sync_req, 1'b1);
    cyc(8);
    b1(mains_close_out, 1'b0);
    b1(m_fb, 1'b0);
    // auto mode, island plant, static sync
    wr(MTB_ADDR_CTRL, 32'h00);
    cyc(8);
    b1(dynamic_sync, 1'b0);
    b1(tie_withdrawn, 1'b0);
    pulse(B_RTC);
    cyc(10);
    b1(tie_close_out, 1'b0);
    setp(B_AUTO, 1'b1);
    cyc(8);
    b1(genset_run, 1'b1);
    setp(B_AUTO, 1'b0);
    cyc(8);
    b1(genset_run, 1'b0);
    setp(B_ALT, 1'b1);
    cyc(8);
    b1(automatic_mains_failure, 1'b1);
    b1(genset_run, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire

// File: mtb_breaker_ctrl.sv
// mains and tie breaker command, interlock and overlap logic with apb regs
//
// The placing of the registers and the APB register port were left to the implementer.
`default_nettype none
// How it works
// R1: static or dynamic sync, dynamic after reset
// R2: upper slip limit 0.0..0.5 Hz, default 0.3
// R3: lower slip limit -0.5..0.3 Hz, default 0.0
// R4: overlap setting limits parallel running time
// R5: overlap only in mains failure or takeover
// R6: tie closed last: open mains before expiry
// R7: mains closed last: open tie before expiry
// R8: overlap time 0.10 to 99.90 seconds
// R9: both never closed beyond overlap time
// R10: auto start/stop input runs genset in auto
// R11: alternative start acts as mains failure
// R12: remote tie close, sync if mains closed
// R13: remote tie open, deload if mains closed
// R14: remote mains close, sync if generator closed
// R15: remote mains open opens at once
// R16: tie close block suppresses tie close
// R17: mains close block suppresses mains close
// R18: tie withdrawn flag in semi/manual
// R19: mains withdrawn flag in semi/manual
// R20: no close output without charged spring
// R21: remote commands pulse, others continuous levels
// R22: pulse commands taken on rising edge
module mtb_breaker_ctrl
  import mtb_pkg::*;
#(
  parameter int TICK_CYCLES = MTB_OVL_TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mtb_pins_s pins_in,
  output logic genset_run,
  output logic automatic_mains_failure,
  output logic dynamic_sync,
  output logic signed [7:0] slip_freq_upper,
  output logic signed [7:0] slip_freq_lower,
  output logic tie_close_out,
  output logic tie_open_out,
  output logic tie_sync_req,
  output logic tie_deload_req,
  output logic mains_close_out,
  output logic mains_open_out,
  output logic mains_sync_req,
  output logic tie_withdrawn,
  output logic mains_withdrawn
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  logic [MTB_PIN_W-1:0] sync1_reg;
  logic [MTB_PIN_W-1:0] sync2_reg;
  mtb_pins_s pin;
  mtb_pins_s pin_prev_reg;
  logic ctrl_dyn_reg;
  logic ctrl_ovl_reg;
  mtb_run_e run_reg;
  mtb_plant_e plant_reg;
  logic signed [7:0] slip_up_reg;
  logic signed [7:0] slip_lo_reg;
  logic [13:0] ovl_lim_reg;
  logic [13:0] ovl_cnt_reg;
  logic [TW-1:0] div_reg;
  logic tick;
  logic last_tie_reg;
  logic tie_pend_reg;
  logic mains_pend_reg;
  logic tie_open_reg;
  logic mains_open_reg;
  mtb_tie_e tie_st_reg;
  mtb_tie_e tie_st_next;
  logic semi;
  logic ovl_act;
  logic both_closed;
  logic ovl_trip;
  logic tie_on_p;
  logic tie_off_p;
  logic mains_on_p;
  logic mains_off_p;
  logic tie_rise;
  logic mains_rise;
  logic wr;
  logic rd;
  logic hit;
  logic signed [7:0] wr_up;
  logic signed [7:0] wr_lo;
  logic [13:0] wr_ovl;

  // two flops per pin; only the second flop feeds logic
  generate
    for (genvar i = 0; i < MTB_PIN_W; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_reg[i] <= 1'b0;
          sync2_reg[i] <= 1'b0;
        end else begin
          sync1_reg[i] <= pins_in[i];
          sync2_reg[i] <= sync1_reg[i];
        end
      end
    end
  endgenerate
  assign pin = mtb_pins_s'(sync2_reg);

  // previous pin levels for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_reg <= '0;
    end else begin
      pin_prev_reg <= pin;
    end
  end

  // R21 remote pulses, other pins levels
  // R22 rising edge only
  // holding a command input high never repeats it
  assign semi = (run_reg == MTB_RUN_SEMI);
  assign tie_on_p = semi && pin.remote_tie_close_cmd &&
                    !pin_prev_reg.remote_tie_close_cmd;
  assign tie_off_p = semi && pin.remote_tie_open_cmd &&
                     !pin_prev_reg.remote_tie_open_cmd;
  assign mains_on_p = semi && pin.remote_mains_close_cmd &&
                      !pin_prev_reg.remote_mains_close_cmd;
  assign mains_off_p = semi && pin.remote_mains_open_cmd &&
                       !pin_prev_reg.remote_mains_open_cmd;
  assign tie_rise = pin.tie_closed_fb && !pin_prev_reg.tie_closed_fb;
  assign mains_rise = pin.mains_closed_fb && !pin_prev_reg.mains_closed_fb;

  // apb decode; zero wait states, error on unmapped address
  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign hit = (paddr == MTB_ADDR_CTRL) || (paddr == MTB_ADDR_SLIP) ||
               (paddr == MTB_ADDR_OVL) || (paddr == MTB_ADDR_STAT);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // clamp written values into their legal ranges
  always_comb begin
    wr_up = signed'(pwdata[7:0]);
    wr_lo = signed'(pwdata[MTB_SLIP_LO_LSB +: 8]);
    wr_ovl = pwdata[13:0];
    // R2 clamp upper slip
    if (wr_up < MTB_SLIP_UP_MIN) wr_up = MTB_SLIP_UP_MIN;
    if (wr_up > MTB_SLIP_UP_MAX) wr_up = MTB_SLIP_UP_MAX;
    // R3 clamp lower slip
    if (wr_lo < MTB_SLIP_LO_MIN) wr_lo = MTB_SLIP_LO_MIN;
    if (wr_lo > MTB_SLIP_LO_MAX) wr_lo = MTB_SLIP_LO_MAX;
    // R8 clamp overlap time
    if (wr_ovl < MTB_OVL_MIN) wr_ovl = MTB_OVL_MIN;
    if (wr_ovl > MTB_OVL_MAX) wr_ovl = MTB_OVL_MAX;
  end

  // R1 control register, dynamic sync after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_dyn_reg <= 1'b1;
      ctrl_ovl_reg <= 1'b0;
      run_reg <= MTB_RUN_RST;
      plant_reg <= MTB_PLANT_RST;
    end else if (wr && paddr == MTB_ADDR_CTRL) begin
      ctrl_dyn_reg <= pwdata[MTB_CTRL_DYN];
      ctrl_ovl_reg <= pwdata[MTB_CTRL_OVL];
      run_reg <= mtb_run_e'(pwdata[MTB_CTRL_RUN_LSB +: 3]);
      plant_reg <= mtb_plant_e'(pwdata[MTB_CTRL_PLANT_LSB +: 3]);
    end
  end

  // R2 R3 slip window, defaults 0.3 and 0.0 Hz
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slip_up_reg <= MTB_SLIP_UP_RST;
      slip_lo_reg <= MTB_SLIP_LO_RST;
    end else if (wr && paddr == MTB_ADDR_SLIP) begin
      slip_up_reg <= wr_up;
      slip_lo_reg <= wr_lo;
    end
  end

  // R8 overlap time limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovl_lim_reg <= MTB_OVL_RST;
    end else if (wr && paddr == MTB_ADDR_OVL) begin
      ovl_lim_reg <= wr_ovl;
    end
  end

  // read mux; status shows the block's live state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd) begin
      case (paddr)
        MTB_ADDR_CTRL: prdata <= {24'h000000, plant_reg, run_reg,
                                  ctrl_ovl_reg, ctrl_dyn_reg};
        MTB_ADDR_SLIP: prdata <= {16'h0000, slip_lo_reg, slip_up_reg};
        MTB_ADDR_OVL: prdata <= {18'h00000, ovl_lim_reg};
        MTB_ADDR_STAT: prdata <= {ovl_cnt_reg, 4'h0, tie_st_reg,
                                  mains_withdrawn, tie_withdrawn,
                                  mains_open_reg, mains_pend_reg,
                                  tie_open_reg, tie_pend_reg,
                                  automatic_mains_failure, genset_run,
                                  pin.generator_breaker_closed_fb,
                                  pin.mains_closed_fb, pin.tie_closed_fb};
        default: prdata <= '0;
      endcase
    end
  end

  assign dynamic_sync = ctrl_dyn_reg;
  assign slip_freq_upper = slip_up_reg;
  assign slip_freq_lower = slip_lo_reg;

  // R11 alternative start acts as a mains failure in any mode
  assign automatic_mains_failure = pin.alt_start || pin.mains_failed;

  // R10 auto start/stop only in auto with a suitable plant mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      genset_run <= 1'b0;
    end else begin
      genset_run <= automatic_mains_failure ||
                    (run_reg == MTB_RUN_AUTO && pin.auto_start_stop &&
                     (plant_reg == MTB_PLANT_ISLAND ||
                      plant_reg == MTB_PLANT_FIXED ||
                      plant_reg == MTB_PLANT_LTO ||
                      plant_reg == MTB_PLANT_MPE));
    end
  end

  // overlap time base: one enable per 10 ms
  assign tick = (div_reg == TW'(TICK_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
    end else if (tick || !both_closed) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // R5 overlap only in mains failure and load takeover plant modes
  assign ovl_act = ctrl_ovl_reg &&
                   (plant_reg == MTB_PLANT_AMF || plant_reg == MTB_PLANT_LTO);
  assign both_closed = pin.tie_closed_fb && pin.mains_closed_fb;

  // R4 parallel time counted in 10 ms steps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovl_cnt_reg <= '0;
    end else if (!both_closed || !ovl_act) begin
      ovl_cnt_reg <= '0;
    end else if (tick && ovl_cnt_reg != MTB_OVL_MAX) begin
      ovl_cnt_reg <= ovl_cnt_reg + 1'b1;
    end
  end

  // R9 trip one step early so the breaker has time to move
  assign ovl_trip = ovl_act && both_closed &&
                    (ovl_cnt_reg >= ovl_lim_reg - 1'b1);

  // which breaker closed last decides which one opens
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_tie_reg <= 1'b0;
    end else if (tie_rise) begin
      last_tie_reg <= 1'b1;
    end else if (mains_rise) begin
      last_tie_reg <= 1'b0;
    end
  end

  // R12 tie close request held until closed or cancelled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tie_pend_reg <= 1'b0;
    end else if (tie_on_p) begin
      tie_pend_reg <= 1'b1;
    end else if (pin.tie_closed_fb || tie_off_p || !semi) begin
      tie_pend_reg <= 1'b0;
    end
  end

  // R14 mains close request held until closed or cancelled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mains_pend_reg <= 1'b0;
    end else if (mains_on_p) begin
      mains_pend_reg <= 1'b1;
    end else if (pin.mains_closed_fb || mains_off_p || !semi) begin
      mains_pend_reg <= 1'b0;
    end
  end

  // R12 sync needed only with the mains breaker closed
  assign tie_sync_req = tie_pend_reg && pin.mains_closed_fb;
  // R14 sync needed only with the generator breaker closed
  assign mains_sync_req = mains_pend_reg && pin.generator_breaker_closed_fb;

  // close outputs gated by block, spring and sync status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tie_close_out <= 1'b0;
      mains_close_out <= 1'b0;
    end else begin
      // R16 R20 tie close gate
      tie_close_out <= tie_pend_reg && !pin.tie_close_block &&
                       pin.tie_charged_feedback && !tie_open_reg &&
                       (!tie_sync_req || pin.sync_ok);
      // R17 R20 mains close gate
      mains_close_out <= mains_pend_reg && !pin.mains_close_block &&
                         pin.mains_charged_feedback && !mains_open_reg &&
                         (!mains_sync_req || pin.sync_ok);
    end
  end

  // R13 tie open sequence: deload first when mains is closed
  always_comb begin
    tie_st_next = tie_st_reg;
    case (tie_st_reg)
      MTB_TIE_IDLE: begin
        if (tie_off_p) begin
          tie_st_next = pin.mains_closed_fb ? MTB_TIE_DELOAD : MTB_TIE_OPEN;
        end
      end
      MTB_TIE_DELOAD: begin
        if (pin.deload_done || !pin.mains_closed_fb) begin
          tie_st_next = MTB_TIE_OPEN;
        end
      end
      MTB_TIE_OPEN: begin
        if (!pin.tie_closed_fb) tie_st_next = MTB_TIE_IDLE;
      end
      default: tie_st_next = MTB_TIE_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tie_st_reg <= MTB_TIE_IDLE;
    end else begin
      tie_st_reg <= tie_st_next;
    end
  end
  assign tie_deload_req = (tie_st_reg == MTB_TIE_DELOAD);

  // R7 tie open hold; a new trip wins over the feedback clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tie_open_reg <= 1'b0;
    end else if ((ovl_trip && !last_tie_reg) ||
                 tie_st_next == MTB_TIE_OPEN) begin
      tie_open_reg <= 1'b1;
    end else if (!pin.tie_closed_fb) begin
      tie_open_reg <= 1'b0;
    end
  end

  // R6 R15 mains open hold, immediate on remote open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mains_open_reg <= 1'b0;
    end else if ((ovl_trip && last_tie_reg) || mains_off_p) begin
      mains_open_reg <= 1'b1;
    end else if (!pin.mains_closed_fb) begin
      mains_open_reg <= 1'b0;
    end
  end
  assign tie_open_out = tie_open_reg;
  assign mains_open_out = mains_open_reg;

  // R18 R19 withdrawn flags, prerequisite is breaker open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tie_withdrawn <= 1'b0;
      mains_withdrawn <= 1'b0;
    end else begin
      tie_withdrawn <= (semi || run_reg == MTB_RUN_MAN) &&
                       pin.tie_withdrawn_in && !pin.tie_closed_fb;
      mains_withdrawn <= (semi || run_reg == MTB_RUN_MAN) &&
                         pin.mains_withdrawn_in && !pin.mains_closed_fb;
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TIE_BLOCK: assert property ( // R16
    pin.tie_close_block |=> !tie_close_out)
    else $error("tie close issued while blocked");
  AST_MAINS_BLOCK: assert property ( // R17
    pin.mains_close_block |=> !mains_close_out)
    else $error("mains close issued while blocked");
  AST_SPRING: assert property ( // R20
    (tie_close_out |-> $past(pin.tie_charged_feedback)) and
    (mains_close_out |-> $past(pin.mains_charged_feedback)))
    else $error("close issued without charged spring");
  AST_OVL_BOUND: assert property ( // R9
    ovl_act && both_closed |-> ovl_cnt_reg <= ovl_lim_reg)
    else $error("parallel time beyond limit");
  AST_OVL_MAINS: assert property ( // R6
    ovl_trip && last_tie_reg |=> mains_open_out)
    else $error("mains not opened on overlap expiry");
  AST_OVL_TIE: assert property ( // R7
    ovl_trip && !last_tie_reg |=> tie_open_out)
    else $error("tie not opened on overlap expiry");
  AST_OVL_MODE: assert property ( // R5
    !(plant_reg == MTB_PLANT_AMF || plant_reg == MTB_PLANT_LTO)
    |=> ovl_cnt_reg == '0)
    else $error("overlap timer runs in wrong plant mode");
  AST_MAINS_OFF: assert property ( // R15
    mains_off_p |=> mains_open_out)
    else $error("remote mains open not immediate");
  AST_TIE_DELOAD: assert property ( // R13
    tie_off_p && pin.mains_closed_fb && tie_st_reg == MTB_TIE_IDLE
    |=> tie_deload_req && !tie_open_out)
    else $error("tie opened without deload");
  AST_PULSE_ONCE: assert property ( // R22
    $rose(tie_pend_reg) |-> $past(tie_on_p))
    else $error("held command repeated");
  AST_SLIP_RANGE: assert property ( // R2
    slip_freq_upper <= MTB_SLIP_UP_MAX && slip_freq_lower >= MTB_SLIP_LO_MIN)
    else $error("slip limit out of range");
  AST_AUTO_STOP: assert property ( // R10
    $fell(pin.auto_start_stop) && !automatic_mains_failure
    ##1 !automatic_mains_failure |-> !genset_run)
    else $error("genset not stopped by auto input");

  COV_TIE_SYNC: cover property (tie_sync_req && pin.sync_ok ##1 tie_close_out);
  COV_OVL_TRIP: cover property (ovl_trip ##1 mains_open_out);
  COV_DELOAD: cover property (tie_deload_req ##[1:20] tie_open_out);
  COV_WITHDRAWN: cover property (tie_withdrawn && mains_withdrawn);
endmodule
`default_nettype wire

// File: mtb_breaker_model.sv
// actuator and deload model standing in for the breakers and plant
`default_nettype none
module mtb_breaker_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic tie_close_out,
  input wire logic tie_open_out,
  input wire logic mains_close_out,
  input wire logic mains_open_out,
  input wire logic tie_deload_req,
  output logic tie_fb,
  output logic mains_fb,
  output logic deload_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] t_q, m_q, d_q;
  // trip coil beats close coil; slow mode adds two cycles of travel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_q <= 3'h0;
      m_q <= 3'h0;
      d_q <= 3'h0;
    end else begin
      t_q <= {t_q[1:0], !tie_open_out && (tie_close_out || t_q[0])};
      m_q <= {m_q[1:0], !mains_open_out && (mains_close_out || m_q[0])};
      d_q <= {d_q[1:0], tie_deload_req};
    end
  end
  // contacts report the mechanism state, late when slow
  assign tie_fb = slow ? t_q[2] : t_q[0];
  assign mains_fb = slow ? m_q[2] : m_q[0];
  assign deload_done = slow ? d_q[2] : d_q[0];
endmodule
`default_nettype wire

// File: mtb_pkg.sv
// package: constants, types and register map of the breaker command logic
`default_nettype none
package mtb_pkg;
  // clock and overlap time base
  localparam int MTB_CLK_PERIOD_NS = 50;
  localparam int MTB_OVL_UNIT_NS = 10_000_000;
  localparam int MTB_OVL_TICK_CYCLES = MTB_OVL_UNIT_NS / MTB_CLK_PERIOD_NS;
  // overlap limit in 10 ms units: 0.10 s .. 99.90 s
  localparam logic [13:0] MTB_OVL_MIN = 14'h000a;
  localparam logic [13:0] MTB_OVL_MAX = 14'h2706;
  localparam logic [13:0] MTB_OVL_RST = 14'h0064;
  // slip limits in 0.1 Hz units, signed
  localparam logic signed [7:0] MTB_SLIP_UP_MIN = 8'sh00;
  localparam logic signed [7:0] MTB_SLIP_UP_MAX = 8'sh05;
  localparam logic signed [7:0] MTB_SLIP_UP_RST = 8'sh03;
  localparam logic signed [7:0] MTB_SLIP_LO_MIN = -8'sh05;
  localparam logic signed [7:0] MTB_SLIP_LO_MAX = 8'sh03;
  localparam logic signed [7:0] MTB_SLIP_LO_RST = 8'sh00;
  // register byte addresses
  localparam logic [7:0] MTB_ADDR_CTRL = 8'h00;
  localparam logic [7:0] MTB_ADDR_SLIP = 8'h04;
  localparam logic [7:0] MTB_ADDR_OVL = 8'h08;
  localparam logic [7:0] MTB_ADDR_STAT = 8'h0c;
  // control and slip register field positions
  localparam int MTB_CTRL_DYN = 0;
  localparam int MTB_CTRL_OVL = 1;
  localparam int MTB_CTRL_RUN_LSB = 2;
  localparam int MTB_CTRL_PLANT_LSB = 5;
  localparam int MTB_SLIP_LO_LSB = 8;
  typedef enum logic [2:0] {
    MTB_RUN_AUTO = 3'h0,
    MTB_RUN_SEMI = 3'h1,
    MTB_RUN_TEST = 3'h2,
    MTB_RUN_MAN = 3'h3,
    MTB_RUN_BLOCK = 3'h4
  } mtb_run_e;
  typedef enum logic [2:0] {
    MTB_PLANT_ISLAND = 3'h0,
    MTB_PLANT_AMF = 3'h1,
    MTB_PLANT_PEAK = 3'h2,
    MTB_PLANT_FIXED = 3'h3,
    MTB_PLANT_MPE = 3'h4,
    MTB_PLANT_LTO = 3'h5
  } mtb_plant_e;
  localparam mtb_run_e MTB_RUN_RST = MTB_RUN_SEMI;
  localparam mtb_plant_e MTB_PLANT_RST = MTB_PLANT_AMF;
  // tie breaker open sequence
  typedef enum logic [2:0] {
    MTB_TIE_IDLE = 3'b001,
    MTB_TIE_DELOAD = 3'b010,
    MTB_TIE_OPEN = 3'b100
  } mtb_tie_e;
  // pins from the plant, all asynchronous to pclk
  typedef struct packed {
    logic auto_start_stop;
    logic alt_start;
    logic mains_failed;
    logic remote_tie_close_cmd;
    logic remote_tie_open_cmd;
    logic remote_mains_close_cmd;
    logic remote_mains_open_cmd;
    logic tie_close_block;
    logic mains_close_block;
    logic tie_withdrawn_in;
    logic mains_withdrawn_in;
    logic tie_charged_feedback;
    logic mains_charged_feedback;
    logic tie_closed_fb;
    logic mains_closed_fb;
    logic generator_breaker_closed_fb;
    logic sync_ok;
    logic deload_done;
  } mtb_pins_s;
  localparam int MTB_PIN_W = $bits(mtb_pins_s);
endpackage
`default_nettype wire
